// *** hfcf_async_framer.sv ***
// async character framer: modulator packing and demodulator unpacking with apb registers
`timescale 1ns/1ns
`default_nettype none
`include "hfcf_defines.svh"

// Functional notes
// - character formats of 7 to 12 bits
// - positive or negative parity selectable
// - insert null when source buffer runs dry
// - null has space data, mark framing
// - receiver drops null characters
// - append end-of-message characters after last character
// - end-of-message character is all mark
// - at least ten, then until block full
// - receiver stops output on end-of-message
// - four interleaving degrees with sequence lengths
// - whole characters between framing sequences
// - fill bits equal encoded minus source bits
// - fill bits come first in each block
// - 75 b/s 7-bit degrees 1,5,12,35
// - 150 b/s 7-bit degrees 1,9,27,81
// - strip framing before coding, regenerate after
// - flow control pauses source on overflow
module hfcf_async_framer #(
	parameter int FIFO_DEPTH = `HFCF_FIFO_DEPTH
) (
	input  wire logic                    sys_clk,
	input  wire logic                    sys_rst,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`HFCF_ADDR_W-1:0] paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire hfcf_pkg::hfcf_src_t     srcIn,
	input  wire logic                    srcValid,
	output logic                         srcReady,
	output logic                         encBit,
	output logic                         encValid,
	output logic                         encFirst,
	input  wire logic                    encReady,
	input  wire logic                    decBit,
	input  wire logic                    decValid,
	input  wire logic                    decFirst,
	output logic      [11:0]             rxChar,
	output logic                         rxValid,
	output logic                         rxEnded
);
	hfcf_pkg::hfcf_cfg_t      cfg_r;
	hfcf_pkg::hfcf_param_t    tblParam;
	hfcf_pkg::hfcf_param_t    param;
	hfcf_pkg::hfcf_src_t      fifoOut;
	hfcf_pkg::hfcf_tx_state_t txState_r;
	logic                     tblHit;
	logic [31:0]              ovr_r;
	logic [31:0]              prdata_r;
	logic [31:0]              rdData;
	logic                     mapped;
	logic                     wrEn;
	logic [3:0]               dataLen;
	logic [3:0]               charLen;
	logic [11:0]              lenMask;
	logic [11:0]              dataMask;
	logic [11:0]              parMask;
	logic [11:0]              frameMask;
	logic                     fifoValid;
	logic                     fifoPop;
	logic                     txBusy;
	logic                     encXfer;
	logic [11:0]              txSr_r;
	logic [3:0]               txBitCnt_r;
	logic [13:0]              blkCnt_r;
	logic [3:0]               eomCnt_r;
	logic                     lastSeen_r;
	logic                     fillDone_r;
	logic [15:0]              nullCnt_r;
	logic                     rxArmed_r;
	logic                     rxEnded_r;
	logic [13:0]              rxPos_r;
	logic [3:0]               rxBit_r;
	logic [11:0]              rxSr_r;
	logic [13:0]              rxCurPos;
	logic [11:0]              rxWord;
	logic [11:0]              rxRegen;

	function automatic hfcf_pkg::hfcf_param_t mk(
		input logic [7:0]  deg,
		input logic [9:0]  sb,
		input logic [13:0] enc,
		input logic [2:0]  fill,
		input logic [8:0]  seq
	);
		mk = '{degree: deg, superBlk: sb, encBits: enc, fill: fill, seqLen: seq};
	endfunction

	// character layout from the format fields
	always_comb
	begin
		dataLen   = `HFCF_MIN_DATA + {2'b00, cfg_r.dataSel};
		charLen   = 4'h1 + dataLen + {3'b000, cfg_r.parEn} + {3'b000, cfg_r.twoStop} + 4'h1;
		lenMask   = ~(12'hfff << charLen);
		dataMask  = (~(12'hfff << dataLen)) << 1;
		parMask   = cfg_r.parEn ? (12'h001 << (dataLen + 4'h1)) : 12'h000;
		frameMask = lenMask & ~dataMask;
	end

	// operational parameters per rate, length and degree
	always_comb
	begin
		tblHit   = 1'b1;
		tblParam = '0;
		if (cfg_r.rate == hfcf_pkg::RATE_75)
		begin
			case ({charLen, cfg_r.degSel})
				6'h1c: tblParam = mk(8'h01, 10'h237, 14'h1a94, 3'h0, 9'h0fc);
				6'h1d: tblParam = mk(8'h05, 10'h0bd, 14'h2c4c, 3'h0, 9'h1a4);
				6'h1e: tblParam = mk(8'h0c, 10'h054, 14'h2f40, 3'h0, 9'h1c0);
				6'h1f: tblParam = mk(8'h23, 10'h012, 14'h1d88, 3'h0, 9'h118);
				6'h20: tblParam = mk(8'h01, 10'h240, 14'h1b00, 3'h0, 9'h100);
				6'h21: tblParam = mk(8'h04, 10'h0ea, 14'h2be0, 3'h0, 9'h1a0);
				6'h22: tblParam = mk(8'h0c, 10'h04b, 14'h2a30, 3'h0, 9'h190);
				6'h23: tblParam = mk(8'h24, 10'h010, 14'h1b00, 3'h0, 9'h100);
				6'h24: tblParam = mk(8'h01, 10'h237, 14'h1a94, 3'h0, 9'h0fc);
				6'h25: tblParam = mk(8'h04, 10'h0fc, 14'h2f40, 3'h0, 9'h1c0);
				6'h26: tblParam = mk(8'h0c, 10'h054, 14'h2f40, 3'h0, 9'h1c0);
				6'h27: tblParam = mk(8'h24, 10'h010, 14'h1b00, 3'h0, 9'h100);
				6'h28: tblParam = mk(8'h01, 10'h249, 14'h1b6c, 3'h0, 9'h104);
				6'h29: tblParam = mk(8'h04, 10'h0f2, 14'h2d60, 3'h6, 9'h1a0);
				6'h2a: tblParam = mk(8'h0c, 10'h04b, 14'h2a30, 3'h0, 9'h190);
				6'h2b: tblParam = mk(8'h23, 10'h012, 14'h1d88, 3'h0, 9'h118);
				6'h2c: tblParam = mk(8'h01, 10'h252, 14'h1bd8, 3'h0, 9'h108);
				6'h2d: tblParam = mk(8'h04, 10'h104, 14'h30c0, 3'h6, 9'h1c0);
				6'h2e: tblParam = mk(8'h0b, 10'h063, 14'h330c, 3'h0, 9'h1e4);
				6'h2f: tblParam = mk(8'h21, 10'h012, 14'h1bd8, 3'h0, 9'h108);
				6'h30: tblParam = mk(8'h01, 10'h237, 14'h1a94, 3'h0, 9'h0fc);
				6'h31: tblParam = mk(8'h04, 10'h105, 14'h30f0, 3'h0, 9'h1d0);
				6'h32: tblParam = mk(8'h0c, 10'h054, 14'h2f40, 3'h0, 9'h1c0);
				6'h33: tblParam = mk(8'h24, 10'h010, 14'h1b00, 3'h0, 9'h100);
				default: tblHit = 1'b0;
			endcase
		end
		else if (cfg_r.rate == hfcf_pkg::RATE_150 && charLen == 4'h7)
		begin
			case (cfg_r.degSel)
				2'h0: tblParam = mk(8'h01, 10'h237, 14'h1a94, 3'h0, 9'h0fc);
				2'h1: tblParam = mk(8'h09, 10'h070, 14'h2f40, 3'h0, 9'h1c0);
				2'h2: tblParam = mk(8'h1b, 10'h023, 14'h2c4c, 3'h0, 9'h1a4);
				default: tblParam = mk(8'h51, 10'h007, 14'h1a94, 3'h0, 9'h0fc);
			endcase
		end
		else
			tblHit = 1'b0;
	end

	always_comb
	begin
		param = tblParam;
		if (!tblHit)
		begin
			param         = '0;
			param.encBits = ovr_r[`HFCF_OVR_ENC_HI:`HFCF_OVR_ENC_LO];
			param.fill    = ovr_r[`HFCF_OVR_FILL_HI:`HFCF_OVR_FILL_LO];
		end
	end

	// apb slave: no wait states; read data is captured into a flop in the setup phase
	assign wrEn    = psel && penable && pwrite;
	assign pready  = psel && penable;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_r;
	assign txBusy  = (txState_r != hfcf_pkg::TX_IDLE);

	always_comb
	begin
		mapped = 1'b1;
		rdData = 32'h0000_0000;
		case (paddr)
			`HFCF_OFF_CTRL:   rdData = 32'h0000_0000;
			`HFCF_OFF_CFG:    rdData = {23'h000000, cfg_r};
			`HFCF_OFF_STAT:   rdData = {nullCnt_r, 8'h00, charLen, tblHit, rxEnded_r,
				rxArmed_r, txBusy};
			`HFCF_OFF_PARAM0: rdData = {5'h00, param.seqLen, param.superBlk, param.degree};
			`HFCF_OFF_PARAM1: rdData = {13'h0000, param.fill, 2'h0, param.encBits};
			`HFCF_OFF_OVR:    rdData = ovr_r;
			default:          mapped = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			prdata_r <= 32'h0000_0000;
		else if (psel && !penable)
			prdata_r <= rdData;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			cfg_r <= `HFCF_CFG_RESET;
			ovr_r <= `HFCF_OVR_RESET;
		end
		else if (wrEn && !txBusy)
		begin
			if (paddr == `HFCF_OFF_CFG)
				cfg_r <= pwdata[8:0];
			if (paddr == `HFCF_OFF_OVR)
				ovr_r <= pwdata & 32'h0007_3fff;
		end
	end

	hfcf_fifo #(
		.WIDTH ($bits(hfcf_pkg::hfcf_src_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.inData   (srcIn),
		.inValid  (srcValid),
		.inReady  (srcReady),
		.outData  (fifoOut),
		.outValid (fifoValid),
		.outReady (fifoPop)
	);

	// modulator: fill bits, then whole characters until the block is full
	assign encXfer  = encValid && encReady;
	assign encValid = (txState_r == hfcf_pkg::TX_FILL) || (txState_r == hfcf_pkg::TX_SHIFT);
	assign encBit   = txSr_r[0];
	assign encFirst = encValid && (blkCnt_r == 14'h0000);
	assign fifoPop  = (txState_r == hfcf_pkg::TX_LOAD) && !lastSeen_r && fifoValid
		&& !(blkCnt_r == 14'h0000 && param.fill != 3'h0 && !fillDone_r);

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			txState_r  <= hfcf_pkg::TX_IDLE;
			txSr_r     <= 12'h000;
			txBitCnt_r <= 4'h0;
			eomCnt_r   <= 4'h0;
			lastSeen_r <= 1'b0;
			fillDone_r <= 1'b0;
		end
		else
		begin
			case (txState_r)
				hfcf_pkg::TX_IDLE:
				begin
					if (wrEn && paddr == `HFCF_OFF_CTRL && pwdata[`HFCF_CTRL_TX_START])
					begin
						txState_r  <= hfcf_pkg::TX_LOAD;
						eomCnt_r   <= 4'h0;
						lastSeen_r <= 1'b0;
						fillDone_r <= 1'b0;
					end
				end
				hfcf_pkg::TX_LOAD:
				begin
					if (eomCnt_r >= `HFCF_EOM_MIN && blkCnt_r == 14'h0000)
						txState_r <= hfcf_pkg::TX_IDLE;
					else if (blkCnt_r == 14'h0000 && param.fill != 3'h0 && !fillDone_r)
					begin
						txSr_r     <= 12'h000;
						txBitCnt_r <= {1'b0, param.fill};
						fillDone_r <= 1'b1;
						txState_r  <= hfcf_pkg::TX_FILL;
					end
					else
					begin
						fillDone_r <= 1'b0;
						txBitCnt_r <= charLen;
						txState_r  <= hfcf_pkg::TX_SHIFT;
						if (lastSeen_r)
						begin
							txSr_r <= lenMask;
							if (eomCnt_r != 4'hf)
								eomCnt_r <= eomCnt_r + 4'h1;
						end
						else if (fifoValid)
						begin
							txSr_r     <= fifoOut.chr & dataMask;
							lastSeen_r <= fifoOut.last;
						end
						else
							txSr_r <= frameMask;
					end
				end
				hfcf_pkg::TX_FILL, hfcf_pkg::TX_SHIFT:
				begin
					if (encXfer)
					begin
						txSr_r     <= txSr_r >> 1;
						txBitCnt_r <= txBitCnt_r - 4'h1;
						if (txBitCnt_r == 4'h1)
							txState_r <= hfcf_pkg::TX_LOAD;
					end
				end
				default: txState_r <= hfcf_pkg::TX_IDLE;
			endcase
		end
	end

	// position in the current block, wrapping at the encoded bit count
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || txState_r == hfcf_pkg::TX_IDLE)
			blkCnt_r <= 14'h0000;
		else if (encXfer)
			blkCnt_r <= (blkCnt_r + 14'h0001 >= param.encBits) ? 14'h0000
				: blkCnt_r + 14'h0001;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			nullCnt_r <= 16'h0000;
		else if (txState_r == hfcf_pkg::TX_LOAD && !fifoValid && !lastSeen_r
			&& nullCnt_r != 16'hffff
			&& !(blkCnt_r == 14'h0000 && param.fill != 3'h0 && !fillDone_r)
			&& !(eomCnt_r >= `HFCF_EOM_MIN && blkCnt_r == 14'h0000))
			nullCnt_r <= nullCnt_r + 16'h0001;
	end

	// demodulator: skip fill, assemble, classify and regenerate framing
	always_comb
	begin
		rxCurPos = decFirst ? 14'h0000 : rxPos_r;
		rxWord   = (rxSr_r | ({11'h000, decBit} << rxBit_r)) & lenMask;
		rxRegen  = (rxWord & dataMask) | (frameMask & ~parMask & ~12'h001);
		if (cfg_r.parEn && ((^(rxWord & dataMask)) ^ cfg_r.parNeg))
			rxRegen = rxRegen | parMask;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			rxArmed_r <= 1'b0;
			rxEnded_r <= 1'b0;
			rxPos_r   <= 14'h0000;
			rxBit_r   <= 4'h0;
			rxSr_r    <= 12'h000;
			rxChar    <= 12'h000;
			rxValid   <= 1'b0;
		end
		else
		begin
			rxValid <= 1'b0;
			if (wrEn && paddr == `HFCF_OFF_CTRL)
			begin
				rxArmed_r <= pwdata[`HFCF_CTRL_RX_ARM];
				rxEnded_r <= 1'b0;
				rxBit_r   <= 4'h0;
				rxSr_r    <= 12'h000;
			end
			else if (decValid && rxArmed_r && !rxEnded_r)
			begin
				rxPos_r <= rxCurPos + 14'h0001;
				if (rxCurPos < {11'h000, param.fill})
				begin
					rxBit_r <= 4'h0;
					rxSr_r  <= 12'h000;
				end
				else if ((decFirst ? 4'h0 : rxBit_r) == charLen - 4'h1)
				begin
					rxBit_r <= 4'h0;
					rxSr_r  <= 12'h000;
					if (rxWord == lenMask)
						rxEnded_r <= 1'b1;
					else if (rxWord != frameMask)
					begin
						rxChar  <= rxRegen;
						rxValid <= 1'b1;
					end
				end
				else if (decFirst)
				begin
					rxBit_r <= 4'h1;
					rxSr_r  <= {11'h000, decBit};
				end
				else
				begin
					rxBit_r <= rxBit_r + 4'h1;
					rxSr_r  <= rxWord;
				end
			end
		end
	end

	assign rxEnded = rxEnded_r;
endmodule
`default_nettype wire

// *** hfcf_async_framer_props.sv ***
// concurrent checks on the ports of the async character framer
`timescale 1ns/1ns
`default_nettype none
`include "hfcf_defines.svh"
module hfcf_async_framer_props (
	input wire logic                    sys_clk,
	input wire logic                    sys_rst,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [`HFCF_ADDR_W-1:0] paddr,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic                    srcValid,
	input wire logic                    srcReady,
	input wire logic                    encBit,
	input wire logic                    encValid,
	input wire logic                    encFirst,
	input wire logic                    encReady,
	input wire logic                    decValid,
	input wire logic [11:0]             rxChar,
	input wire logic                    rxValid,
	input wire logic                    rxEnded
);
	logic ctrlWr;

	// any control write reloads the arm bit and clears the ended flag, so only then may the ended flag drop
	assign ctrlWr = psel && penable && pwrite && paddr == `HFCF_OFF_CTRL;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_stall;
		encValid && !encReady;
	endsequence

	property p_pready; psel && penable |-> pready; endproperty
	a_pready: assert property (p_pready) else $error("no ready in access phase");
	property p_err_acc; pslverr |-> psel && penable; endproperty
	a_err_acc: assert property (p_err_acc) else $error("slave error outside access phase");
	property p_enc_hold; s_stall |=> encValid && $stable(encBit); endproperty
	a_enc_hold: assert property (p_enc_hold) else $error("encoded bit dropped while stalled");
	property p_first_valid; encFirst |-> (encValid and (encReady |=> !encFirst)); endproperty
	a_first_valid: assert property (p_first_valid) else $error("block start without a bit");
	property p_src_flow; $fell(srcReady) |-> $past(srcValid); endproperty
	a_src_flow: assert property (p_src_flow) else $error("source paused without a push");
	property p_rx_follows; rxValid |-> $past(decValid) && !rxChar[0]; endproperty
	a_rx_follows: assert property (p_rx_follows) else $error("character out of turn");
	property p_rx_pulse; rxValid |=> !rxValid; endproperty
	a_rx_pulse: assert property (p_rx_pulse) else $error("character strobe held");
	property p_ended_quiet; rxEnded |-> !rxValid; endproperty
	a_ended_quiet: assert property (p_ended_quiet) else $error("output after message end");
	property p_ended_stays; rxEnded && !ctrlWr |=> rxEnded; endproperty
	a_ended_stays: assert property (p_ended_stays) else $error("message end flag lost");
endmodule
bind hfcf_async_framer hfcf_async_framer_props i_hfcf_async_framer_props (.sys_clk, .sys_rst,
	.psel, .penable, .pwrite, .paddr, .pready, .pslverr, .srcValid, .srcReady, .encBit,
	.encValid, .encFirst, .encReady, .decValid, .rxChar, .rxValid, .rxEnded);
`default_nettype wire

// *** hfcf_defines.svh ***
// offsets, field positions, reset values and counts of the async character framer
`ifndef HFCF_DEFINES_SVH
`define HFCF_DEFINES_SVH

`define HFCF_ADDR_W        8
`define HFCF_OFF_CTRL      8'h00
`define HFCF_OFF_CFG       8'h04
`define HFCF_OFF_STAT      8'h08
`define HFCF_OFF_PARAM0    8'h0c
`define HFCF_OFF_PARAM1    8'h10
`define HFCF_OFF_OVR       8'h14

`define HFCF_CTRL_TX_START 0
`define HFCF_CTRL_RX_ARM   1

`define HFCF_CFG_DATA_LO   0
`define HFCF_CFG_DATA_HI   1
`define HFCF_CFG_PAR_EN    2
`define HFCF_CFG_PAR_NEG   3
`define HFCF_CFG_TWO_STOP  4
`define HFCF_CFG_RATE_LO   5
`define HFCF_CFG_RATE_HI   6
`define HFCF_CFG_DEG_LO    7
`define HFCF_CFG_DEG_HI    8
`define HFCF_CFG_RESET     9'h000

`define HFCF_OVR_ENC_LO    0
`define HFCF_OVR_ENC_HI    13
`define HFCF_OVR_FILL_LO   16
`define HFCF_OVR_FILL_HI   18
`define HFCF_OVR_RESET     32'h0000_1a94

`define HFCF_EOM_MIN       4'ha
`define HFCF_MIN_DATA      4'h5
`define HFCF_FIFO_DEPTH    16

`endif

// *** hfcf_fifo.sv ***
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module hfcf_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    rdPtr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	assign inReady  = (count_r != DEPTH[AW:0]);
	assign outValid = (count_r != '0);
	assign outData  = mem[rdPtr_r];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wrPtr_r] <= inData;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (push)
				wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
			if (pop)
				rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule
`default_nettype wire

// *** hfcf_pkg.sv ***
// types shared by the async character framer, its source model and bench
package hfcf_pkg;

	typedef enum logic [1:0] {RATE_75, RATE_150, RATE_300, RATE_600} hfcf_rate_t;

	typedef struct packed {
		logic [1:0] degSel;
		hfcf_rate_t rate;
		logic       twoStop;
		logic       parNeg;
		logic       parEn;
		logic [1:0] dataSel;
	} hfcf_cfg_t;

	typedef struct packed {
		logic [7:0]  degree;
		logic [9:0]  superBlk;
		logic [13:0] encBits;
		logic [2:0]  fill;
		logic [8:0]  seqLen;
	} hfcf_param_t;

	typedef struct packed {
		logic        last;
		logic [11:0] chr;
	} hfcf_src_t;

	typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_FILL, TX_SHIFT} hfcf_tx_state_t;

endpackage

// *** hfcf_src_model.sv ***
// behavioural source terminal that feeds start/stop characters under flow control
`timescale 1ns/1ns
`default_nettype none
module hfcf_src_model #(
	parameter int N_CHARS = 20,
	parameter int GAP_AT  = 18,
	parameter int GAP     = 400
) (
	input  wire logic               sys_clk,
	input  wire logic               go,
	input  wire logic               srcReady,
	output var hfcf_pkg::hfcf_src_t srcIn,
	output logic                    srcValid,
	output logic                    sawFull
);
	initial
	begin
		int i;
		srcIn = '0;
		srcValid = 0;
		sawFull = 0;
		wait (go);
		@(posedge sys_clk);
		for (int k = 0; k < N_CHARS; k++)
		begin
			// a pause long enough to starve the modem's buffer
			if (k == GAP_AT)
			begin
				srcValid <= 0;
				srcIn <= ~srcIn;
				repeat (GAP) @(posedge sys_clk);
			end
			srcIn <= {k == N_CHARS - 1, 5'h1f, 1'b1, 5'(k * 7 + 3), 1'b0};
			srcValid <= 1;
			i = 0;
			do
			begin
				@(posedge sys_clk);
				i++;
				if (!srcReady)
					sawFull <= 1;
			end
			while (!srcReady && i < 5000);
		end
		srcValid <= 0;
		srcIn <= ~srcIn;
	end
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the async character framer
`timescale 1ns/1ns
`default_nettype none
`include "hfcf_defines.svh"
module tb;
	logic                sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
	logic                srcValid, srcReady, encBit, encValid, encFirst;
	logic                encReady = 1'b0;
	logic                decBit, decValid, decFirst, rxValid, rxEnded, go, sawFull;
	logic [7:0]          paddr;
	logic [31:0]         pwdata, prdata, r;
	logic [11:0]         rxChar;
	hfcf_pkg::hfcf_src_t srcIn;
	int                  err_total, n_checks;
	int                  cyc = 0;
	logic                bits[$];
	int                  fst[$];
	logic [11:0]         rq[$];

	hfcf_async_framer i_hfcf_async_framer (.sys_clk, .sys_rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .srcIn, .srcValid, .srcReady, .encBit,
		.encValid, .encFirst, .encReady, .decBit, .decValid, .decFirst, .rxChar, .rxValid,
		.rxEnded);
	hfcf_src_model i_hfcf_src_model (.sys_clk, .go, .srcReady, .srcIn, .srcValid, .sawFull);

	initial
	begin
		sys_clk = 0;
		forever #4 sys_clk = ~sys_clk;
	end

	// encoder side stalls one cycle in four
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		encReady <= cyc % 4 != 0;
		if (encValid && encReady)
		begin
			if (encFirst)
				fst.push_back(bits.size());
			bits.push_back(encBit);
		end
		if (rxValid)
			rq.push_back(rxChar);
	end

	task automatic summarize;
		if (err_total == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		i = 0;
		do
		begin
			@(posedge sys_clk);
			i++;
		end
		while (!pready && i < 20);
		if (!pready)
		begin
			err_total++;
			summarize();
		end
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk);
	endtask

	task automatic dsend(input logic [7:0] v, input int n, input logic f);
		for (int j = 0; j < n; j++)
		begin
			decBit <= v[j];
			decValid <= 1;
			decFirst <= f && j == 0;
			@(posedge sys_clk);
		end
	endtask

	task automatic t_regs;
		int deg[6] = '{1, 5, 12, 35, 1, 9};
		int sb[6] = '{567, 189, 84, 18, 567, 112};
		int sq[6] = '{252, 420, 448, 280, 252, 448};
		apb(0, `HFCF_OFF_CFG, 0);
		chk(r, 0);
		apb(0, `HFCF_OFF_OVR, 0);
		chk(r, 32'h0000_1a94);
		apb(1, 8'h40, 32'h1);
		chk(e, 1);
		apb(0, 8'h40, 0);
		chk(r, 0);
		for (int i = 0; i < 6; i++)
		begin
			apb(1, `HFCF_OFF_CFG, (i / 4) * 32'h20 + (i % 4) * 32'h80);
			apb(0, `HFCF_OFF_PARAM0, 0);
			chk(r, {5'h0, sq[i][8:0], sb[i][9:0], deg[i][7:0]});
		end
		apb(1, `HFCF_OFF_CFG, 32'h86);
		apb(0, `HFCF_OFF_PARAM1, 0);
		chk(r, 32'h0006_2d60);
		apb(0, `HFCF_OFF_PARAM0, 0);
		chk(r, {5'h0, 9'd416, 10'd242, 8'd4});
		apb(0, `HFCF_OFF_STAT, 0);
		chk(r[7:4], 4'ha);
	endtask

	task automatic t_tx;
		int i, k, nul, end_of_message_char;
		logic [6:0] ch;
		apb(1, `HFCF_OFF_CFG, 32'h40);
		apb(1, `HFCF_OFF_OVR, 32'h0002_001e);
		go <= 1;
		i = 0;
		while (!sawFull && i < 500)
		begin
			@(posedge sys_clk);
			i++;
		end
		chk(sawFull, 1);
		if (!sawFull)
			summarize();
		apb(1, `HFCF_OFF_CTRL, 32'h1);
		apb(1, `HFCF_OFF_OVR, 32'h0);
		apb(0, `HFCF_OFF_OVR, 0);
		chk(r, 32'h0002_001e);
		i = 0;
		do
		begin
			apb(0, `HFCF_OFF_STAT, 0);
			i++;
		end
		while (r[0] && i < 1000);
		chk(r[0], 0);
		if (r[0])
			summarize();
		chk(bits.size() % 30, 0);
		chk(fst.size(), bits.size() / 30);
		for (i = 0; i < fst.size(); i++)
			chk(fst[i], 30 * i);
		k = 0;
		nul = 0;
		end_of_message_char = 0;
		// two fill bits open each block, then four whole characters
		for (i = 0; i + 7 <= bits.size(); i += 7)
		begin
			if (i % 30 == 0)
				i += 2;
			for (int j = 0; j < 7; j++)
				ch[j] = bits[i + j];
			if (ch === 7'h41)
				nul++;
			else if (ch === 7'h7f)
				end_of_message_char++;
			else
			begin
				chk(ch, {1'b0, 5'(k * 7 + 3), 1'b0});
				chk(end_of_message_char, 0);
				k++;
			end
		end
		chk(k, 20);
		chk(nul > 0, 1);
		chk(r[31:16], nul);
		chk(end_of_message_char, 10 + (4 - (k + nul + 10) % 4) % 4);
	endtask

	task automatic t_rx(input logic neg);
		logic [4:0] a1 = 5'h16;
		logic [4:0] a2 = 5'h03;
		apb(1, `HFCF_OFF_OVR, 32'h0002_0022);
		apb(1, `HFCF_OFF_CFG, 32'h44 + 32'(neg) * 8);
		apb(1, `HFCF_OFF_CTRL, 32'h2);
		rq.delete();
		dsend(8'h03, 2, 1);
		dsend({2'b0, a1, 1'b0}, 8, 0);
		dsend(8'hc1, 8, 0);
		dsend({2'b0, a2, 1'b0}, 8, 0);
		dsend(8'hff, 8, 0);
		dsend(8'h03, 2, 1);
		dsend({2'b0, a1, 1'b0}, 8, 0);
		decValid <= 0;
		repeat (3) @(posedge sys_clk);
		chk(rq.size(), 2);
		if (rq.size() == 2)
		begin
			chk(rq[0][7:0], {1'b1, ^a1 ^ neg, a1, 1'b0});
			chk(rq[1][7:0], {1'b1, ^a2 ^ neg, a2, 1'b0});
		end
		chk(rxEnded, 1);
		apb(0, `HFCF_OFF_STAT, 0);
		chk(r[2], 1);
	endtask

	initial
	begin
		sys_rst = 1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{decBit, decValid, decFirst, go} = '0;
		{err_total, n_checks} = '0;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 0;
		@(posedge sys_clk);
		t_regs();
		t_tx();
		t_rx(0);
		t_rx(1);
		summarize();
	end
endmodule
`default_nettype wire
